// file: list_cmd_pkg.sv
// Shared types and constants for the list sample and trigger command block.
// Assumes commands arrive already parsed into one cmd_t per request.
package list_cmd_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;

  // Durations travel in microseconds.
  localparam logic [15:0] TIME_MIN_US  = 16'h00FA;
  localparam logic [15:0] TIME_MAX_US  = 16'h84D0;
  localparam logic [8:0]  AVG_MIN      = 9'h002;
  localparam logic [8:0]  AVG_MAX      = 9'h100;
  localparam logic [3:0]  SAMPLE_SLOTS = 4'h8;
  localparam logic [12:0] WAVE_PTS_MAX = 13'h0F5D;
  localparam logic [12:0] LIST_SMALL   = 13'h0B86;
  localparam logic [12:0] LIST_MID     = 13'h0F5D;
  localparam logic [12:0] LIST_LARGE   = 13'h170C;

  localparam logic [15:0] ERR_NONE     = 16'h0000;
  localparam logic [15:0] ERR_CMD      = 16'hFF9C;
  localparam logic [15:0] ERR_CONFLICT = 16'hFF23;
  localparam logic [15:0] ERR_RANGE    = 16'hFF22;
  localparam logic [15:0] ERR_TOO_MUCH = 16'hFF21;
  localparam logic [15:0] ERR_LENGTH   = 16'hFF1E;

  localparam logic [15:0] CHAR_V = 16'h0056;
  localparam logic [15:0] CHAR_C = 16'h0043;

  typedef enum logic [3:0] {
    OP_CLEAR, OP_VOLT_ENTRY, OP_CURR_ENTRY, OP_DWELL_ENTRY,
    OP_SAMP_VOLT, OP_SAMP_CURR, OP_SAMP_QUERY, OP_SAMP_DUR,
    OP_SAMP_DUR_Q, OP_TRIG_CFG, OP_TRIG_WIDTH_Q, OP_SET_WAIT,
    OP_WAIT_Q, OP_TRIG_POINT, OP_NEXT_LOC_Q, OP_ERR_Q
  } cmd_op_t;

  typedef enum logic [1:0] {RSP_NUM, RSP_CHAR, RSP_ERR} rsp_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_SQRY = 3'b100
  } state_t;

  typedef struct packed {
    cmd_op_t     op;
    logic [15:0] arg;
    logic [15:0] value;
    logic        polarity;
  } cmd_t;

  typedef struct packed {
    logic        last;
    rsp_kind_t   kind;
    logic [15:0] data;
  } rsp_t;

endpackage

// file: list_sample_trigger_config.sv
// Command handling for list sampling, trigger pulses and wait timeout.
// Assumes one parsed command per cycle on cmdValid while cmdReady is high.
`timescale 1ns/1ps
module list_sample_trigger_config
  import list_cmd_pkg::*;
#(
  parameter int CYCLES_PER_US = CYC_PER_US,
  parameter int ERRQ_DEPTH    = 8
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        cmdValid,
  input  wire cmd_t        cmd,
  input  wire logic        mainChannelSelect,
  input  wire logic [1:0]  resSel,
  input  wire logic        outputOffStatus,
  input  wire logic [12:0] listRdAddr,
  output logic             cmdReady,
  output logic             rspValid,
  output rsp_t             rsp,
  output logic             flagConducts,
  output logic             pulseActive,
  output logic [15:0]      pulseLevel,
  output logic [15:0]      waitTimeoutUs,
  output logic [15:0]      listRdData
);

  localparam int EW = $clog2(ERRQ_DEPTH);

  function automatic logic [8:0] roundAvg(input logic [15:0] a);
    logic [8:0] r;
    r = AVG_MIN;
    for (int i = 8; i >= 1; i--) begin
      if (a >= (16'h0001 << i) && r == AVG_MIN) begin
        r = 9'(16'h0001 << i);
      end
    end
    return r;
  endfunction

  function automatic logic inRange(input logic [15:0] t);
    return t >= TIME_MIN_US && t <= TIME_MAX_US;
  endfunction

  logic [15:0] listMem [LIST_LARGE];
  logic [12:0] sampPts [SAMPLE_SLOTS];
  logic [15:0] errMem  [ERRQ_DEPTH];

  state_t      state_q, state_d;
  cmd_op_t     lastOp_q, lastOp_d;
  logic [12:0] mainCount_q, mainCount_d, currCount_q, currCount_d;
  logic [12:0] dwellCount_q, dwellCount_d;
  logic [3:0]  sampCount_q, sampCount_d, qIdx_q, qIdx_d;
  logic [8:0]  fillLeft_q, fillLeft_d;
  logic [15:0] fillVal_q, fillVal_d;
  logic        sampSet_q, sampSet_d, trigSet_q, trigSet_d;
  logic        waitSet_q, waitSet_d, trigMode_q, trigMode_d;
  logic        trigPol_q, trigPol_d;
  logic [15:0] sampUs_q, sampUs_d, trigUs_q, trigUs_d, waitUs_q, waitUs_d;
  logic [23:0] pulseCnt_q, pulseCnt_d;
  logic [15:0] pulseLevel_d;
  logic        flag_d, rspValid_d, cmdReady_d;
  rsp_t        rsp_d;
  logic [EW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [EW:0]   errCnt_q, errCnt_d;
  logic          listWe, errPush, sampWe;
  logic [12:0]   listWAddr;
  logic [15:0]   listWData, errCode, errHead;
  logic [12:0]   listLimit;
  logic          take, prevList, lenEq;

  assign take      = ce && cmdValid && cmdReady && state_q == ST_IDLE;
  assign errHead   = errMem[rdPtr_q];
  assign listLimit = resSel == 2'h0 ? LIST_SMALL :
                     resSel == 2'h1 ? LIST_MID : LIST_LARGE;
  assign prevList  = lastOp_q == OP_VOLT_ENTRY ||
                     lastOp_q == OP_CURR_ENTRY;
  assign lenEq     = dwellCount_q == mainCount_q;

  always_comb begin
    state_d = state_q; lastOp_d = lastOp_q;
    mainCount_d = mainCount_q; currCount_d = currCount_q;
    dwellCount_d = dwellCount_q; sampCount_d = sampCount_q;
    qIdx_d = qIdx_q; fillLeft_d = fillLeft_q; fillVal_d = fillVal_q;
    sampSet_d = sampSet_q; trigSet_d = trigSet_q; waitSet_d = waitSet_q;
    trigMode_d = trigMode_q; trigPol_d = trigPol_q;
    sampUs_d = sampUs_q; trigUs_d = trigUs_q; waitUs_d = waitUs_q;
    pulseCnt_d = pulseCnt_q == 24'h000000 ? pulseCnt_q
                                          : pulseCnt_q - 24'h000001;
    pulseLevel_d = pulseLevel;
    rspValid_d = 1'b0; rsp_d = '0;
    listWe = 1'b0; listWAddr = mainCount_q; listWData = cmd.value;
    errPush = 1'b0; errCode = ERR_NONE; sampWe = 1'b0;
    rdPtr_d = rdPtr_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          lastOp_d = cmd.op;
          case (cmd.op)
            OP_CLEAR: begin
              mainCount_d = '0; currCount_d = '0; dwellCount_d = '0;
              sampCount_d = '0; sampSet_d = 1'b0; trigSet_d = 1'b0;
              trigMode_d = 1'b0;
            end
            OP_VOLT_ENTRY, OP_CURR_ENTRY: begin
              if (cmd.op == OP_VOLT_ENTRY && currCount_q != '0) begin
                errPush = 1'b1; errCode = ERR_CONFLICT;
              end else if (mainCount_q >= listLimit) begin
                errPush = 1'b1; errCode = ERR_TOO_MUCH;
              end else begin
                listWe = 1'b1;
                mainCount_d = mainCount_q + 13'h0001;
                if (cmd.op == OP_CURR_ENTRY) begin
                  currCount_d = currCount_q + 13'h0001;
                end
              end
            end
            OP_DWELL_ENTRY: begin
              if (dwellCount_q < listLimit) begin
                dwellCount_d = dwellCount_q + 13'h0001;
              end
            end
            OP_SAMP_VOLT, OP_SAMP_CURR: begin
              errPush = 1'b1;
              if (!sampSet_q) begin
                errCode = ERR_CONFLICT;
              end else if (!prevList && lastOp_q != OP_SAMP_DUR) begin
                errCode = ERR_CONFLICT;
              end else if (!lenEq) begin
                errCode = ERR_LENGTH;
              end else if (sampCount_q == SAMPLE_SLOTS) begin
                errCode = ERR_TOO_MUCH;
              end else if ({1'b0, mainCount_q} + {5'h00, roundAvg(cmd.arg)}
                           > {1'b0, WAVE_PTS_MAX}) begin
                errCode = ERR_TOO_MUCH;
              end else begin
                errPush = 1'b0;
                sampWe = 1'b1;
                sampCount_d = sampCount_q + 4'h1;
                fillLeft_d = roundAvg(cmd.arg);
                fillVal_d = cmd.value;
                state_d = ST_FILL;
              end
            end
            OP_SAMP_QUERY: begin
              qIdx_d = '0;
              state_d = ST_SQRY;
            end
            OP_SAMP_DUR: begin
              if (sampSet_q) begin
                errPush = 1'b1; errCode = ERR_CMD;
              end else if (!inRange(cmd.arg)) begin
                errPush = 1'b1; errCode = ERR_RANGE;
              end else begin
                sampSet_d = 1'b1; sampUs_d = cmd.arg;
              end
            end
            OP_TRIG_CFG: begin
              if (!inRange(cmd.arg)) begin
                errPush = 1'b1; errCode = ERR_RANGE;
              end else begin
                trigSet_d = 1'b1; trigUs_d = cmd.arg;
                trigPol_d = cmd.polarity;
                trigMode_d = 1'b1;
              end
            end
            OP_SET_WAIT: begin
              if (!inRange(cmd.arg)) begin
                errPush = 1'b1; errCode = ERR_RANGE;
              end else begin
                waitSet_d = 1'b1; waitUs_d = cmd.arg;
              end
            end
            OP_SAMP_DUR_Q, OP_TRIG_WIDTH_Q: begin
              rspValid_d = 1'b1; rsp_d.last = 1'b1;
              if (cmd.op == OP_SAMP_DUR_Q ? !sampSet_q : !trigSet_q) begin
                rsp_d.kind = RSP_ERR; rsp_d.data = ERR_CMD;
                errPush = 1'b1; errCode = ERR_CMD;
              end else begin
                rsp_d.data = cmd.op == OP_SAMP_DUR_Q ? sampUs_q : trigUs_q;
              end
            end
            OP_WAIT_Q: begin
              rspValid_d = 1'b1; rsp_d.last = 1'b1;
              rsp_d.data = waitSet_q ? waitUs_q : 16'h0000;
            end
            OP_NEXT_LOC_Q: begin
              rspValid_d = 1'b1; rsp_d.last = 1'b1;
              rsp_d.data = {3'h0, mainCount_q};
            end
            OP_ERR_Q: begin
              rspValid_d = 1'b1; rsp_d.last = 1'b1;
              if (errCnt_q != '0) begin
                rsp_d.data = errHead;
                rdPtr_d = EW'(rdPtr_q + 1'b1);
              end
            end
            OP_TRIG_POINT: begin
              errPush = 1'b1;
              if (!trigSet_q) begin
                errCode = ERR_CONFLICT;
              end else if (!prevList) begin
                errCode = ERR_CONFLICT;
              end else if (!lenEq) begin
                errCode = ERR_LENGTH;
              end else if (mainCount_q >= listLimit) begin
                errCode = ERR_TOO_MUCH;
              end else begin
                errPush = 1'b0; listWe = 1'b1;
                mainCount_d = mainCount_q + 13'h0001;
                pulseLevel_d = cmd.value;
                pulseCnt_d = 24'(trigUs_q * CYCLES_PER_US);
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_FILL: begin
        if (ce) begin
          listWe = 1'b1; listWData = fillVal_q;
          mainCount_d = mainCount_q + 13'h0001;
          fillLeft_d = fillLeft_q - 9'h001;
          if (fillLeft_q == 9'h001) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_SQRY: begin
        if (ce) begin
          rspValid_d = 1'b1;
          if (qIdx_q == sampCount_q) begin
            rsp_d.last = 1'b1; rsp_d.kind = RSP_CHAR;
            rsp_d.data = mainChannelSelect ? CHAR_C : CHAR_V;
            state_d = ST_IDLE;
          end else begin
            rsp_d.data = {3'h0, sampPts[qIdx_q[2:0]]};
            qIdx_d = qIdx_q + 4'h1;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!ce) begin
      pulseCnt_d = pulseCnt_q;
    end
    // The flag normally conducts while the output is off.
    flag_d = trigMode_d ? ((pulseCnt_d != '0) == trigPol_d)
                        : outputOffStatus;
    cmdReady_d = state_d == ST_IDLE;
    // A full queue drops the newest error, keeping the oldest ones.
    wrPtr_d = errPush && errCnt_q != (EW+1)'(ERRQ_DEPTH) ?
              EW'(wrPtr_q + 1'b1) : wrPtr_q;
    errCnt_d = errCnt_q + (EW+1)'(wrPtr_d != wrPtr_q)
                        - (EW+1)'(rdPtr_d != rdPtr_q);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE; lastOp_q <= OP_CLEAR;
      mainCount_q <= '0; currCount_q <= '0; dwellCount_q <= '0;
      sampCount_q <= '0; qIdx_q <= '0; fillLeft_q <= '0; fillVal_q <= '0;
      sampSet_q <= 1'b0; trigSet_q <= 1'b0; waitSet_q <= 1'b0;
      trigMode_q <= 1'b0; trigPol_q <= 1'b0;
      sampUs_q <= '0; trigUs_q <= '0; waitUs_q <= '0; pulseCnt_q <= '0;
      wrPtr_q <= '0; rdPtr_q <= '0; errCnt_q <= '0;
      cmdReady <= 1'b0; rspValid <= 1'b0; rsp <= '0;
      flagConducts <= 1'b0; pulseActive <= 1'b0; pulseLevel <= '0;
      waitTimeoutUs <= '0;
    end else if (ce) begin
      state_q <= state_d; lastOp_q <= lastOp_d;
      mainCount_q <= mainCount_d; currCount_q <= currCount_d;
      dwellCount_q <= dwellCount_d; sampCount_q <= sampCount_d;
      qIdx_q <= qIdx_d; fillLeft_q <= fillLeft_d; fillVal_q <= fillVal_d;
      sampSet_q <= sampSet_d; trigSet_q <= trigSet_d;
      waitSet_q <= waitSet_d; trigMode_q <= trigMode_d;
      trigPol_q <= trigPol_d; sampUs_q <= sampUs_d; trigUs_q <= trigUs_d;
      waitUs_q <= waitUs_d; pulseCnt_q <= pulseCnt_d;
      wrPtr_q <= wrPtr_d; rdPtr_q <= rdPtr_d; errCnt_q <= errCnt_d;
      cmdReady <= cmdReady_d; rspValid <= rspValid_d; rsp <= rsp_d;
      flagConducts <= flag_d; pulseActive <= pulseCnt_d != '0;
      pulseLevel <= pulseLevel_d;
      waitTimeoutUs <= waitSet_d ? waitUs_d : 16'h0000;
    end
  end

  // Storage arrays carry no reset; counters mark what is valid.
  always_ff @(posedge mclk) begin
    if (listWe) begin
      listMem[listWAddr] <= listWData;
    end
    if (sampWe) begin
      sampPts[sampCount_q[2:0]] <= mainCount_q;
    end
    if (wrPtr_d != wrPtr_q) begin
      errMem[wrPtr_q] <= errCode;
    end
    if (ce) begin
      listRdData <= listMem[listRdAddr];
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence sTrigOk;
    take && cmd.op == OP_TRIG_POINT && trigSet_q && prevList && lenEq &&
    mainCount_q < listLimit;
  endsequence
  sequence sTrigPulse;
    pulseActive && flagConducts == trigPol_q;
  endsequence

  a_trig_pulse: assert property (sTrigOk |=> sTrigPulse and
    pulseLevel == $past(cmd.value)) else $error("trigger pulse wrong");
  a_trig_unset: assert property (take && cmd.op == OP_TRIG_POINT &&
    !trigSet_q |-> errPush && errCode == ERR_CONFLICT)
    else $error("trigger without width accepted");
  a_samp_once: assert property (take && cmd.op == OP_SAMP_DUR &&
    sampSet_q |-> errPush && errCode == ERR_CMD)
    else $error("repeat sample duration accepted");
  a_samp_cap: assert property (take && sampCount_q == SAMPLE_SLOTS &&
    (cmd.op == OP_SAMP_VOLT || cmd.op == OP_SAMP_CURR) |-> !sampWe)
    else $error("too many samples recorded");
  a_fill_start: assert property (take && sampWe |=>
    state_q == ST_FILL && fillLeft_q == roundAvg($past(cmd.arg)))
    else $error("sample fill wrong length");
  a_volt_conf: assert property (take && cmd.op == OP_VOLT_ENTRY &&
    currCount_q != '0 |-> errPush && errCode == ERR_CONFLICT && !listWe)
    else $error("voltage entry over current list");
  a_wait_zero: assert property (take && cmd.op == OP_WAIT_Q &&
    !waitSet_q |=> rspValid && rsp.data == 16'h0000)
    else $error("unset timeout not zero");
  a_errq_order: assert property (take && cmd.op == OP_ERR_Q &&
    errCnt_q != '0 |=> rsp.data == $past(errHead))
    else $error("error queue out of order");
  a_clear_loc: assert property (take && cmd.op == OP_CLEAR |=>
    mainCount_q == '0 && !trigMode_q)
    else $error("clear left list state");

endmodule

// file: host_model.sv
// Host-side model that issues parsed commands and collects the responses.
// Assumes the device takes a command on an edge where cmdReady is high.
`timescale 1ns/1ps
module host_model
  import list_cmd_pkg::*;
(
  input  wire logic mclk,
  input  wire logic cmdReady,
  input  wire logic rspValid,
  input  wire rsp_t rsp,
  output logic      cmdValid,
  output cmd_t      cmd
);
  rsp_t rspQ[$];

  initial begin
    cmdValid = 1'b0;
    cmd      = '0;
  end

  always @(posedge mclk) begin
    if (rspValid === 1'b1) begin
      rspQ.push_back(rsp);
    end
  end

  // One whole command per request keeps every line short.
  task automatic send(input cmd_op_t op, input logic [15:0] arg,
                      input logic [15:0] val, input logic pol);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmd      <= '{op, arg, val, pol};
    do @(posedge mclk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    // Released fields must not keep showing the last request.
    cmd      <= cmd_t'(~{op, arg, val, pol});
  endtask

  // A missing beat comes back as unknown so that no compare can match it.
  task automatic take(output rsp_t r);
    int n;
    n = 0;
    while (rspQ.size() == 0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    r = (rspQ.size() != 0) ? rspQ.pop_front() : 'x;
  endtask
endmodule

// file: list_sample_trigger_config_tb.sv
// Self-checking bench for the list sample and trigger command block.
// Assumes host_model drives the command port; pulses run at 1 cycle per us.
`timescale 1ns/1ps
module list_sample_trigger_config_tb
  import list_cmd_pkg::*;
;
  typedef struct {
    cmd_op_t     op;
    logic [15:0] arg;
    logic [15:0] val;
    int          chk;
    logic [15:0] want;
  } row_t;

  logic        mclk;
  logic        rst_b;
  logic        ce;
  logic        mainChannelSelect;
  logic        outputOffStatus;
  logic [1:0]  resSel;
  logic [12:0] listRdAddr;
  logic        cmdValid;
  cmd_t        cmd;
  logic        cmdReady;
  logic        rspValid;
  rsp_t        rsp;
  logic        flagConducts;
  logic        pulseActive;
  logic [15:0] pulseLevel;
  logic [15:0] waitTimeoutUs;
  logic [15:0] listRdData;
  int          mismatches;
  int          checked;

  // chk: 0 none, 1 own answer, 2 error queue head, 3 answer plus letter.
  row_t rows[27] = '{
    '{OP_SAMP_VOLT, 16'h0002, 16'h0000, 2, ERR_CONFLICT},
    '{OP_TRIG_POINT, 16'h0000, 16'h0000, 2, ERR_CONFLICT},
    '{OP_SAMP_DUR, 16'h00F9, 16'h0000, 2, ERR_RANGE},
    '{OP_SAMP_DUR, 16'h00FA, 16'h0000, 2, ERR_NONE},
    '{OP_SAMP_DUR, 16'h00FA, 16'h0000, 2, ERR_CMD},
    '{OP_SAMP_VOLT, 16'h0002, 16'h0000, 2, ERR_CONFLICT},
    '{OP_VOLT_ENTRY, 16'h0000, 16'h1111, 0, ERR_NONE},
    '{OP_SAMP_VOLT, 16'h0002, 16'h0000, 2, ERR_LENGTH},
    '{OP_DWELL_ENTRY, 16'h0000, 16'h0000, 0, ERR_NONE},
    '{OP_DWELL_ENTRY, 16'h0000, 16'h0000, 0, ERR_NONE},
    '{OP_VOLT_ENTRY, 16'h0000, 16'h2222, 0, ERR_NONE},
    '{OP_SAMP_VOLT, 16'h0003, 16'h0000, 2, ERR_NONE},
    '{OP_SAMP_QUERY, 16'h0000, 16'h0000, 3, 16'h0002},
    '{OP_NEXT_LOC_Q, 16'h0000, 16'h0000, 1, 16'h0004},
    '{OP_SAMP_DUR_Q, 16'h0000, 16'h0000, 1, 16'h00FA},
    '{OP_TRIG_WIDTH_Q, 16'h0000, 16'h0000, 1, ERR_CMD},
    '{OP_ERR_Q, 16'h0000, 16'h0000, 1, ERR_CMD},
    '{OP_ERR_Q, 16'h0000, 16'h0000, 1, ERR_NONE},
    '{OP_WAIT_Q, 16'h0000, 16'h0000, 1, 16'h0000},
    '{OP_SET_WAIT, 16'h84D0, 16'h0000, 2, ERR_NONE},
    '{OP_WAIT_Q, 16'h0000, 16'h0000, 1, 16'h84D0},
    '{OP_SET_WAIT, 16'h84D1, 16'h0000, 2, ERR_RANGE},
    '{OP_CURR_ENTRY, 16'h0000, 16'h0000, 0, ERR_NONE},
    '{OP_VOLT_ENTRY, 16'h0000, 16'h3333, 2, ERR_CONFLICT},
    '{OP_CLEAR, 16'h0000, 16'h0000, 0, ERR_NONE},
    '{OP_NEXT_LOC_Q, 16'h0000, 16'h0000, 1, 16'h0000},
    '{OP_WAIT_Q, 16'h0000, 16'h0000, 1, 16'h84D0}
  };

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  list_sample_trigger_config #(
    .CYCLES_PER_US (1),
    .ERRQ_DEPTH    (8)
  ) dut (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .ce                (ce),
    .cmdValid          (cmdValid),
    .cmd               (cmd),
    .mainChannelSelect (mainChannelSelect),
    .resSel            (resSel),
    .outputOffStatus   (outputOffStatus),
    .listRdAddr        (listRdAddr),
    .cmdReady          (cmdReady),
    .rspValid          (rspValid),
    .rsp               (rsp),
    .flagConducts      (flagConducts),
    .pulseActive       (pulseActive),
    .pulseLevel        (pulseLevel),
    .waitTimeoutUs     (waitTimeoutUs),
    .listRdData        (listRdData)
  );

  host_model host (
    .mclk     (mclk),
    .cmdReady (cmdReady),
    .rspValid (rspValid),
    .rsp      (rsp),
    .cmdValid (cmdValid),
    .cmd      (cmd)
  );

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic errChk(input string what, input logic [15:0] want);
    rsp_t r;
    host.send(OP_ERR_Q, 16'h0000, 16'h0000, 1'b0);
    host.take(r);
    check(what, r.data, want);
  endtask

  task automatic fill(input int n, input bit withDwell);
    for (int i = 0; i < n; i++) begin
      if (withDwell) host.send(OP_DWELL_ENTRY, 16'h0000, 16'h0000, 1'b0);
      host.send(OP_VOLT_ENTRY, 16'h0000, i[15:0], 1'b0);
    end
  endtask

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The tests need about 23000 cycles, so 60000 cycles leave ample margin.
  initial begin
    #600_000;
    mismatches++;
    give_verdict();
  end

  initial begin
    rsp_t r;
    int   n;
    rst_b = 1'b0;
    ce = 1'b1;
    mainChannelSelect = 1'b0;
    outputOffStatus = 1'b0;
    resSel = 2'h1;
    listRdAddr = 13'h0000;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge mclk);
    #1;
    check("ready in reset", {15'h0000, cmdReady}, 16'h0000);
    check("pulse in reset", {15'h0000, pulseActive}, 16'h0000);
    check("flag in reset", {15'h0000, flagConducts}, 16'h0000);
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    $display("reset test done");

    foreach (rows[i]) begin
      host.send(rows[i].op, rows[i].arg, rows[i].val, 1'b0);
      if (rows[i].chk == 2) errChk("error code", rows[i].want);
      if (rows[i].chk == 1 || rows[i].chk == 3) begin
        host.take(r);
        check("response", r.data, rows[i].want);
      end
      if (rows[i].chk == 3) begin
        host.take(r);
        check("list letter", r.data, CHAR_V);
        check("last beat", {15'h0000, r.last}, 16'h0001);
      end
    end
    check("wait port", waitTimeoutUs, 16'h84D0);
    @(posedge mclk);
    listRdAddr <= 13'h0001;
    repeat (2) @(posedge mclk);
    #1;
    check("table word", listRdData, 16'h2222);
    $display("table test done");

    // A full small table refuses one more entry.
    resSel <= 2'h0;
    host.send(OP_CLEAR, 16'h0000, 16'h0000, 1'b0);
    fill(2950, 1'b0);
    host.send(OP_VOLT_ENTRY, 16'h0000, 16'h0000, 1'b0);
    errChk("capacity", ERR_TOO_MUCH);
    $display("capacity test done");

    resSel <= 2'h2;
    host.send(OP_CLEAR, 16'h0000, 16'h0000, 1'b0);
    host.send(OP_SAMP_DUR, 16'h03E8, 16'h0000, 1'b0);
    fill(3932, 1'b1);
    host.send(OP_SAMP_VOLT, 16'h0002, 16'h0000, 1'b0);
    errChk("point budget", ERR_TOO_MUCH);
    $display("point budget test done");

    // Two dwell entries after each sample keep both lists the same length.
    host.send(OP_CLEAR, 16'h0000, 16'h0000, 1'b0);
    host.send(OP_SAMP_DUR, 16'h00FA, 16'h0000, 1'b0);
    for (int k = 0; k < 9; k++) begin
      fill(1, 1'b1);
      host.send(OP_SAMP_VOLT, 16'h0002, 16'h0000, 1'b0);
      repeat (2) host.send(OP_DWELL_ENTRY, 16'h0000, 16'h0000, 1'b0);
    end
    errChk("ninth sample", ERR_TOO_MUCH);
    mainChannelSelect <= 1'b1;
    host.send(OP_SAMP_QUERY, 16'h0000, 16'h0000, 1'b0);
    for (int k = 0; k < 9; k++) begin
      host.take(r);
      if (k < 8) check("sample index", r.data, 16'(3 * k + 1));
    end
    check("current letter", r.data, CHAR_C);
    $display("sample count test done");

    outputOffStatus <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check("wait after reset", waitTimeoutUs, 16'h0000);
    check("status flag", {15'h0000, flagConducts}, 16'h0001);
    host.send(OP_TRIG_CFG, 16'h00FA, 16'h0000, 1'b1);
    repeat (2) @(posedge mclk);
    #1;
    check("flag idle", {15'h0000, flagConducts}, 16'h0000);
    host.send(OP_TRIG_POINT, 16'h0000, 16'h1234, 1'b1);
    errChk("trigger order", ERR_CONFLICT);
    host.send(OP_DWELL_ENTRY, 16'h0000, 16'h0000, 1'b0);
    host.send(OP_VOLT_ENTRY, 16'h0000, 16'h0001, 1'b0);
    host.send(OP_TRIG_POINT, 16'h0000, 16'h1234, 1'b1);
    #1;
    check("pulse start", {15'h0000, pulseActive}, 16'h0001);
    check("flag on", {15'h0000, flagConducts}, 16'h0001);
    check("pulse level", pulseLevel, 16'h1234);
    n = 0;
    while (pulseActive === 1'b1 && n < 1000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("pulse cycles", n[15:0], 16'h00FA);
    check("flag after", {15'h0000, flagConducts}, 16'h0000);
    host.send(OP_CLEAR, 16'h0000, 16'h0000, 1'b0);
    repeat (2) @(posedge mclk);
    #1;
    check("flag cleared", {15'h0000, flagConducts}, 16'h0001);
    $display("trigger test done");
    give_verdict();
  end
endmodule
